//--- slice_cond_pkg.sv
// constants for the pattern slice condition block
`default_nettype none
package slice_cond_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_SOURCE = 8'h04;
   localparam logic [7:0] ADDR_MATCH = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   // condition field positions
   localparam int SLICE6_COND_LSB = 26;
   localparam int SLICE7_COND_LSB = 29;
   localparam int COND_W = 3;
   // source field positions (own register)
   localparam int SLICE6_SRC_LSB = 0;
   localparam int SLICE7_SRC_LSB = 3;
   localparam int SRC_W = 3;
   localparam int NUM_INPUTS = 8;
   // reset values
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam logic [5:0] SOURCE_RESET = 6'h00;
   localparam logic [1:0] MASK_RESET = 2'h0;
   // condition codes
   typedef enum logic [2:0] {
      COND_TRUE = 3'b000,
      COND_RISE = 3'b001,
      COND_FALL = 3'b010,
      COND_EDGE = 3'b011,
      COND_HIGH = 3'b100,
      COND_LOW = 3'b101,
      COND_FALSE = 3'b110,
      COND_EVENT = 3'b111
   } cond_t;
endpackage : slice_cond_pkg
`default_nettype wire

//--- slice_eval.sv
// one bit slice: input select, sync, edge detect and condition evaluation
`timescale 1ns/1ps
`default_nettype none
module slice_eval (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // configuration
   input wire logic [2:0] condition,
   input wire logic [2:0] source,
   input wire logic clear_edges,
   // pins
   input wire logic [7:0] pins,
   // result
   output logic match,
   output logic event_seen
);
   logic sync_a;
   logic sync_b;
   logic prev;
   logic rise_sticky;
   logic fall_sticky;
   logic next_sync_a;
   logic next_sync_b;
   logic next_prev;
   logic next_rise_sticky;
   logic next_fall_sticky;
   logic rise_now;
   logic fall_now;
   logic [2:0] src_a;
   logic [2:0] src_b;
   logic [2:0] src_p;
   logic [2:0] next_src_a;
   logic [2:0] next_src_b;
   logic [2:0] next_src_p;
   logic same_source;

   always_comb begin
      next_sync_a = pins[source];
      next_sync_b = sync_a;
      next_prev = sync_b;
      // each stage remembers which input it sampled
      next_src_a = source;
      next_src_b = src_a;
      next_src_p = src_b;
      // a change of source is no pin edge: compare only samples of one input
      same_source = (src_b == src_p);
      rise_now = sync_b & ~prev & same_source;
      fall_now = ~sync_b & prev & same_source;
      // write clears detectors; an edge in the same cycle still sets
      next_rise_sticky = (rise_sticky & ~clear_edges) | rise_now;
      next_fall_sticky = (fall_sticky & ~clear_edges) | fall_now;
      event_seen = rise_now | fall_now;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev <= 1'b0;
         rise_sticky <= 1'b0;
         fall_sticky <= 1'b0;
         src_a <= 3'h0;
         src_b <= 3'h0;
         src_p <= 3'h0;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         prev <= next_prev;
         rise_sticky <= next_rise_sticky;
         fall_sticky <= next_fall_sticky;
         src_a <= next_src_a;
         src_b <= next_src_b;
         src_p <= next_src_p;
      end
   end

   always_comb begin
      case (slice_cond_pkg::cond_t'(condition))
         slice_cond_pkg::COND_TRUE: match = 1'b1;
         slice_cond_pkg::COND_RISE: match = rise_sticky;
         slice_cond_pkg::COND_FALL: match = fall_sticky;
         slice_cond_pkg::COND_EDGE: match = rise_sticky | fall_sticky;
         slice_cond_pkg::COND_HIGH: match = sync_b;
         slice_cond_pkg::COND_LOW: match = ~sync_b;
         slice_cond_pkg::COND_FALSE: match = 1'b0;
         slice_cond_pkg::COND_EVENT: match = rise_now | fall_now;
         default: match = 1'b0;
      endcase
   end
endmodule : slice_eval
`default_nettype wire

//--- pattern_slice_condition.sv
// match-condition evaluation for bit slices 6 and 7 with register port
//
// What this block does
// - slice 6 condition at bits 28:26
// - slice 7 condition at bits 31:29
// - code 0: always true
// - code 1: sticky rising edge
// - code 2: sticky falling edge
// - code 3: sticky either edge
// - config or source write clears sticky edges
// - code 4: true while input high
// - code 5: true while input low
// - code 6: never matches, for unused slices
// - code 7: one-cycle edge event
// - source value selects same-index input
`timescale 1ns/1ps
`default_nettype none
module pattern_slice_condition (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // pattern inputs
   input wire logic [7:0] pattern_in,
   // results
   output logic slice6_match,
   output logic slice7_match,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] pattern_slice_config;
   logic [5:0] pattern_slice_source;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic [31:0] next_config;
   logic [5:0] next_source;
   logic [1:0] next_status;
   logic [1:0] next_mask;
   logic [31:0] next_rdata;
   logic clear_edges;
   logic [1:0] event_seen;
   logic [1:0] match_vec;
   logic wr_config;
   logic wr_source;
   logic status_read;
   logic [2:0] slice6_condition;
   logic [2:0] slice7_condition;

   assign wr_config = reg_write && (reg_addr == slice_cond_pkg::ADDR_CONFIG);
   assign wr_source = reg_write && (reg_addr == slice_cond_pkg::ADDR_SOURCE);
   assign status_read = reg_read && (reg_addr == slice_cond_pkg::ADDR_IRQ_STATUS);
   // named condition fields of the two slices
   assign slice6_condition = pattern_slice_config[slice_cond_pkg::SLICE6_COND_LSB +: slice_cond_pkg::COND_W];
   assign slice7_condition = pattern_slice_config[slice_cond_pkg::SLICE7_COND_LSB +: slice_cond_pkg::COND_W];
   // clear on config or source write only
   assign clear_edges = wr_config | wr_source;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_config = pattern_slice_config;
      next_source = pattern_slice_source;
      next_mask = irq_mask;
      next_rdata = 32'h0000_0000;
      if (wr_config) begin
         next_config = reg_wdata;
      end
      if (wr_source) begin
         next_source = reg_wdata[5:0];
      end
      if (reg_write && (reg_addr == slice_cond_pkg::ADDR_IRQ_MASK)) begin
         next_mask = reg_wdata[1:0];
      end
      // set wins over read-clear so no event is lost
      next_status = (status_read ? 2'h0 : irq_status) | event_seen;
      if (reg_read) begin
         case (reg_addr)
            slice_cond_pkg::ADDR_CONFIG: next_rdata = pattern_slice_config;
            slice_cond_pkg::ADDR_SOURCE: next_rdata = {26'h000_0000, pattern_slice_source};
            slice_cond_pkg::ADDR_MATCH: next_rdata = {30'h0000_0000, match_vec};
            slice_cond_pkg::ADDR_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
            slice_cond_pkg::ADDR_IRQ_MASK: next_rdata = {30'h0000_0000, irq_mask};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pattern_slice_config <= slice_cond_pkg::CONFIG_RESET;
         pattern_slice_source <= slice_cond_pkg::SOURCE_RESET;
         irq_status <= 2'h0;
         irq_mask <= slice_cond_pkg::MASK_RESET;
         reg_rdata <= 32'h0000_0000;
      end else begin
         pattern_slice_config <= next_config;
         pattern_slice_source <= next_source;
         irq_status <= next_status;
         irq_mask <= next_mask;
         reg_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // slice 6 evaluation
   slice_eval u_slice6 (
      .sys_clk(sys_clk),
      .rst(rst),
      .condition(slice6_condition),
      .source(pattern_slice_source[slice_cond_pkg::SLICE6_SRC_LSB +: slice_cond_pkg::SRC_W]),
      .clear_edges(clear_edges),
      .pins(pattern_in),
      .match(match_vec[0]),
      .event_seen(event_seen[0])
   );

   slice_eval u_slice7 (
      .sys_clk(sys_clk),
      .rst(rst),
      .condition(slice7_condition),
      .source(pattern_slice_source[slice_cond_pkg::SLICE7_SRC_LSB +: slice_cond_pkg::SRC_W]),
      .clear_edges(clear_edges),
      .pins(pattern_in),
      .match(match_vec[1]),
      .event_seen(event_seen[1])
   );

   // match is combinational off registered state so event mode lasts one cycle
   assign slice6_match = match_vec[0];
   assign slice7_match = match_vec[1];
   assign irq = |(irq_status & irq_mask);
endmodule : pattern_slice_condition
`default_nettype wire

//--- slice_cond_sva.sv
// assertions for the slice condition block
`timescale 1ns/1ps
`default_nettype none
module slice_cond_sva (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // pins and results
   input wire logic [7:0] pattern_in,
   input wire logic slice6_match,
   input wire logic slice7_match,
   input wire logic irq
);
   logic [2:0] c6, c7, s6, s7, q;
   logic clr;
   assign clr = reg_write && (reg_addr == slice_cond_pkg::ADDR_CONFIG || reg_addr == slice_cond_pkg::ADDR_SOURCE);
   // q counts quiet cycles, so no pin sample from before a write is judged
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {c7, c6, s7, s6, q} <= 15'h0000;
      end else begin
         if (reg_write && reg_addr == slice_cond_pkg::ADDR_CONFIG) {c7, c6} <= reg_wdata[31:26];
         if (reg_write && reg_addr == slice_cond_pkg::ADDR_SOURCE) {s7, s6} <= reg_wdata[5:0];
         q <= clr ? 3'h0 : (q == 3'h4 ? q : q + 3'h1);
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_const_true: assert property (c6 == 3'h0 |-> slice6_match) else $error("slice6 not true");
   a_const_false: assert property (c7 == 3'h6 |-> !slice7_match) else $error("slice7 matched");
   a_level_high: assert property (q == 3'h4 && c6 == 3'h4 |-> slice6_match == $past(pattern_in[s6], 2))
      else $error("high level wrong");
   a_level_low: assert property (q == 3'h4 && c7 == 3'h5 |-> slice7_match == !$past(pattern_in[s7], 2))
      else $error("low level wrong");
   a_event_pulse: assert property (q == 3'h4 && c6 == 3'h7
      |-> slice6_match == ($past(pattern_in[s6], 2) != $past(pattern_in[s6], 3))) else $error("event wrong");
   a_rise_seen: assert property (q == 3'h4 && c6 == 3'h1 && !clr && $past(pattern_in[s6], 2)
      && !$past(pattern_in[s6], 3) |=> slice6_match) else $error("rise missed");
   a_sticky_hold: assert property (slice6_match && c6 inside {[3'h1:3'h3]} && !clr |=> slice6_match)
      else $error("sticky lost");
   a_cfg_readback: assert property ($past(reg_read && reg_addr == slice_cond_pkg::ADDR_CONFIG)
      |-> reg_rdata[31:26] == {c7, c6}) else $error("config readback");
endmodule : slice_cond_sva
bind pattern_slice_condition slice_cond_sva u_sva (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
   .reg_read, .reg_rdata, .pattern_in, .slice6_match, .slice7_match, .irq);
`default_nettype wire

//--- pin_model.sv
// pin model: drives the pattern inputs as the far side would
`timescale 1ns/1ps
`default_nettype none
module pin_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // wanted levels and pins
   input wire logic [7:0] want,
   output logic [7:0] pattern_in
);
   // pins move only after an edge, never mid-cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) pattern_in <= 8'h00;
      else pattern_in <= want;
   end
endmodule : pin_model
`default_nettype wire

//--- tb.sv
// testbench for the slice condition block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk, rst, reg_write, reg_read, slice6_match, slice7_match, irq;
   logic [7:0] reg_addr, want, pattern_in;
   logic [31:0] reg_wdata, reg_rdata;
   int error_cnt, n_checks, hi;
   // expected match {before, after rise, after fall} per code
   localparam logic [2:0] T [8] = '{3'h7, 3'h3, 3'h1, 3'h3, 3'h2, 3'h5, 3'h0, 3'h0};
   pattern_slice_condition u_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .pattern_in, .slice6_match, .slice7_match, .irq);
   pin_model u_pins (.sys_clk, .rst, .want, .pattern_in);
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_write <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_read <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'h0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   task automatic pin(input logic [7:0] v);
      @(posedge sys_clk);
      want <= v;
   endtask : pin
   task automatic cyc(input int n);
      hi = 0;
      repeat (n) begin
         @(posedge sys_clk);
         #1 hi += int'(slice6_match);
      end
   endtask : cyc
   ////////////////////////////////////////////////////////////
   // slices 6 and 7 on inputs 6 and 7 through every condition code
   task automatic all_codes();
      for (int c = 0; c < 8; c++) begin
         wr(slice_cond_pkg::ADDR_CONFIG, (32'(c) << slice_cond_pkg::SLICE6_COND_LSB) |
            (32'(c) << slice_cond_pkg::SLICE7_COND_LSB));
         cyc(4);
         chk(32'(slice6_match), 32'(T[c][2]));
         chk(32'(slice7_match), 32'(T[c][2]));
         pin(8'hc0);
         cyc(6);
         chk(32'(slice6_match), 32'(T[c][1]));
         chk(32'(slice7_match), 32'(T[c][1]));
         if (c == 7) chk(32'(hi), 32'h0000_0001);
         pin(8'h00);
         cyc(6);
         chk(32'(slice6_match), 32'(T[c][0]));
         chk(32'(slice7_match), 32'(T[c][0]));
      end
   endtask : all_codes
   // sticky clear, interrupt and readback
   task automatic sticky_irq();
      wr(slice_cond_pkg::ADDR_CONFIG, 32'hc400_0000);
      wr(slice_cond_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      rd(slice_cond_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
      pin(8'h40);
      cyc(6);
      chk(32'(irq), 32'h0000_0001);
      chk(32'(slice7_match), 32'h0000_0000);
      rd(slice_cond_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
      cyc(1);
      chk(32'(irq), 32'h0000_0000);
      wr(slice_cond_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      pin(8'h00);
      cyc(6);
      chk(32'(irq), 32'h0000_0000);
      chk(32'(slice6_match), 32'h0000_0001);
      rd(slice_cond_pkg::ADDR_MATCH, 32'h0000_0001);
      wr(slice_cond_pkg::ADDR_SOURCE, 32'h0000_003e);
      cyc(2);
      chk(32'(slice6_match), 32'h0000_0000);
      rd(slice_cond_pkg::ADDR_CONFIG, 32'hc400_0000);
      rd(8'h20, 32'h0000_0000);
      pin(8'h40);
      cyc(6);
      chk(32'(slice6_match), 32'h0000_0001);
      // moving the source between a low and a high input is no edge
      wr(slice_cond_pkg::ADDR_SOURCE, 32'h0000_003d);
      cyc(4);
      wr(slice_cond_pkg::ADDR_SOURCE, 32'h0000_003e);
      cyc(6);
      chk(32'(slice6_match), 32'h0000_0000);
      rd(slice_cond_pkg::ADDR_SOURCE, 32'h0000_003e);
   endtask : sticky_irq
   // reset in mid-run returns both condition fields to zero
   task automatic reset_again();
      @(posedge sys_clk);
      rst <= 1'h1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'h0;
      rd(slice_cond_pkg::ADDR_CONFIG, 32'h0000_0000);
      chk(32'(slice7_match), 32'h0000_0001);
   endtask : reset_again
   task automatic complete_run();
      $display("mismatches %0d checks %0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   initial begin
      {rst, reg_write, reg_read, reg_addr, reg_wdata, want} = {3'h4, 48'h0};
      error_cnt = 0;
      n_checks = 0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'h0;
      rd(slice_cond_pkg::ADDR_CONFIG, 32'h0000_0000);
      wr(slice_cond_pkg::ADDR_SOURCE, 32'h0000_003e);
      all_codes();
      sticky_irq();
      reset_again();
      complete_run();
   end
endmodule : tb
`default_nettype wire
